//--- inc/memory_map_regs.vh
// register offsets, field positions, reset values and map constants for the memory map decoder
`ifndef MEMORY_MAP_REGS_VH
`define MEMORY_MAP_REGS_VH

// -----------------------------------------------------------------
// core register offsets within every bank
// -----------------------------------------------------------------
`define OFS_INDIRECT_PORT  7'h00
`define OFS_PC_LOW         7'h02
`define OFS_STATUS         7'h03
`define OFS_FSP            7'h04
`define OFS_PC_LATCH       7'h0A
`define OFS_INT_CTRL       7'h0B

// -----------------------------------------------------------------
// status register fields
// -----------------------------------------------------------------
`define STATUS_BANK_LO     5
`define STATUS_BANK_HI     6
`define STATUS_IRP_BIT     7

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define RST_STATUS         8'h18
`define RST_FSP            8'h00
`define RST_PC_LATCH       8'h00
`define RST_INT_CTRL       8'h00
`define RST_PC             13'h0000

// -----------------------------------------------------------------
// program space
// -----------------------------------------------------------------
`define PC_WIDTH           13
`define RESET_VECTOR       13'h0000
`define INT_VECTOR         13'h0004
`define PROG_MASK_1K       13'h03FF
`define PROG_MASK_2K       13'h07FF
`define PROG_MASK_4K       13'h0FFF

// -----------------------------------------------------------------
// data space split
// -----------------------------------------------------------------
`define SFR_LIMIT          7'h20
`define SHARED_BASE        7'h70
`define SMALL_GPR_TOP      7'h6F
`define LARGE_GPR_TOP      7'h3F

// -----------------------------------------------------------------
// variant codes
// -----------------------------------------------------------------
`define VAR_SMALL          2'h0
`define VAR_MID            2'h1
`define VAR_LARGE          2'h2

`endif

//--- hdl/memory_map_bank_decoder.v
// program and data memory map decoder with banked register file
//
// How it works
// - 13-bit program counter over 8K word space
// - fetch address wraps to implemented 1K/2K/4K size
// - reset starts at word 0, interrupt at 4
// - data space split into four banks
// - lowest 32 offsets decode to special registers
// - upper 96 offsets decode to static RAM
// - top 16 bytes of banks 1-3 map bank 0
// - unimplemented locations read zero, ignore writes
// - status bank field selects bank 0 to 3
// - RAM capacity 96, 128 or 208 bytes by variant
// - every register reachable direct or through pointer
// - plain special registers stored and accessed like RAM
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "memory_map_regs.vh"

module memory_map_bank_decoder #(
  parameter [1:0] VARIANT = `VAR_LARGE
) (
  input  wire        SYS_CLK,
  input  wire        RST,
  input  wire        PC_LOAD,
  input  wire [12:0] PC_LOAD_VAL,
  input  wire        PC_INC,
  input  wire        INT_ENTRY,
  input  wire [6:0]  ADDR,
  input  wire [7:0]  WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [7:0]  RDATA,
  output reg  [12:0] PC,
  output wire [12:0] FETCH_ADDR,
  output wire [1:0]  BANK_SEL
);

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // address kinds, binary coded
  localparam [1:0] KIND_NONE = 2'h0;
  localparam [1:0] KIND_CORE = 2'h1;
  localparam [1:0] KIND_SFR  = 2'h2;
  localparam [1:0] KIND_RAM  = 2'h3;

  // implemented program words per variant
  function [12:0] prog_mask;
    input [1:0] v;
    begin
      if (v == `VAR_SMALL) begin
        prog_mask = `PROG_MASK_1K;
      end else if (v == `VAR_MID) begin
        prog_mask = `PROG_MASK_2K;
      end else begin
        prog_mask = `PROG_MASK_4K;
      end
    end
  endfunction

  // core register offsets, the same in every bank
  function is_core_ofs;
    input [6:0] o;
    begin
      is_core_ofs = 1'b0;
      if (o == `OFS_INDIRECT_PORT) begin
        is_core_ofs = 1'b1;
      end else if (o == `OFS_PC_LOW) begin
        is_core_ofs = 1'b1;
      end else if (o == `OFS_STATUS) begin
        is_core_ofs = 1'b1;
      end else if (o == `OFS_FSP) begin
        is_core_ofs = 1'b1;
      end else if (o == `OFS_PC_LATCH) begin
        is_core_ofs = 1'b1;
      end else if (o == `OFS_INT_CTRL) begin
        is_core_ofs = 1'b1;
      end
    end
  endfunction

  // banked ram above the special registers, shared window excluded
  function ram_present;
    input [1:0] b;
    input [6:0] o;
    input [1:0] v;
    begin
      ram_present = 1'b0;
      if (b == 2'h0) begin
        ram_present = 1'b1;
      end else if (b == 2'h1) begin
        if (v != `VAR_SMALL && o <= `LARGE_GPR_TOP) begin
          ram_present = 1'b1;
        end
      end else if (b == 2'h2) begin
        if (v == `VAR_LARGE && o <= `SMALL_GPR_TOP) begin
          ram_present = 1'b1;
        end
      end
    end
  endfunction

  // classify a full 9-bit data address into one of the kinds above
  function [1:0] kind_of;
    input [8:0] a;
    input [1:0] v;
    reg   [6:0] o;
    begin
      o = a[6:0];
      kind_of = KIND_NONE;
      if (o < `SFR_LIMIT) begin
        if (is_core_ofs(o)) begin
          kind_of = KIND_CORE;
        end else begin
          kind_of = KIND_SFR;
        end
      end else if (o >= `SHARED_BASE) begin
        kind_of = KIND_RAM;
      end else if (ram_present(a[8:7], o, v)) begin
        kind_of = KIND_RAM;
      end
    end
  endfunction

  // physical ram index, shared window folded onto bank 0
  function [8:0] ram_index;
    input [8:0] a;
    begin
      if (a[6:0] >= `SHARED_BASE) begin
        ram_index = {2'h0, a[6:0]};
      end else begin
        ram_index = a;
      end
    end
  endfunction

  // plain special register store, one set of 32 per bank
  function [6:0] sfr_index;
    input [8:0] a;
    begin
      sfr_index = {a[8:7], a[4:0]};
    end
  endfunction

  // -----------------------------------------------------------------
  // core registers
  // -----------------------------------------------------------------
  reg [7:0] status_q;
  reg [7:0] fsp_q;
  reg [7:0] pc_latch_q;
  reg [7:0] int_ctrl_q;
  reg [7:0] ram [0:511];
  reg [7:0] special_function_space [0:127];

  // -----------------------------------------------------------------
  // bank and fetch outputs
  // -----------------------------------------------------------------
  assign BANK_SEL   = status_q[`STATUS_BANK_HI:`STATUS_BANK_LO];
  assign FETCH_ADDR = PC & prog_mask(VARIANT);

  // -----------------------------------------------------------------
  // address formation
  // -----------------------------------------------------------------
  wire       indirect  = (ADDR == `OFS_INDIRECT_PORT);
  wire [8:0] direct_a  = {BANK_SEL, ADDR};
  wire [8:0] ind_a     = {status_q[`STATUS_IRP_BIT], fsp_q};
  reg  [8:0] eff_a;
  always @* begin
    if (indirect) begin
      eff_a = ind_a;
    end else begin
      eff_a = direct_a;
    end
  end
  wire [1:0] kind      = kind_of(eff_a, VARIANT);
  wire [8:0] ridx      = ram_index(eff_a);
  wire [6:0] sidx      = sfr_index(eff_a);
  wire [6:0] eoff      = eff_a[6:0];
  // pointer aimed at the port itself reads zero and writes nothing
  wire       self_ind  = indirect && (eoff == `OFS_INDIRECT_PORT);
  wire       ram_we    = WR && !self_ind && kind == KIND_RAM;
  wire       sfr_we    = WR && !self_ind && kind == KIND_SFR;
  wire       core_wr   = WR && !self_ind && kind == KIND_CORE;

  // -----------------------------------------------------------------
  // core register selects
  // -----------------------------------------------------------------
  // same offset in every bank, so only the low seven bits matter
  wire       pcl_sel   = (eoff == `OFS_PC_LOW);
  wire       st_sel    = (eoff == `OFS_STATUS);
  wire       fsp_sel   = (eoff == `OFS_FSP);
  wire       latch_sel = (eoff == `OFS_PC_LATCH);
  wire       ictl_sel  = (eoff == `OFS_INT_CTRL);
  wire       pcl_wr    = core_wr && pcl_sel;

  // -----------------------------------------------------------------
  // program counter
  // -----------------------------------------------------------------
  reg [12:0] pc_d;
  always @* begin
    pc_d = PC;
    if (INT_ENTRY) begin
      pc_d = `INT_VECTOR;
    end else if (pcl_wr) begin
      pc_d = {pc_latch_q[4:0], WDATA};
    end else if (PC_LOAD) begin
      pc_d = PC_LOAD_VAL;
    end else if (PC_INC) begin
      pc_d = PC + 13'h0001;
    end
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PC <= `RESET_VECTOR;
    end else begin
      PC <= pc_d;
    end
  end

  // -----------------------------------------------------------------
  // core register writes
  // -----------------------------------------------------------------
  reg [7:0] status_d;
  reg [7:0] fsp_d;
  reg [7:0] pc_latch_d;
  reg [7:0] int_ctrl_d;

  always @* begin
    status_d = status_q;
    if (core_wr && st_sel) begin
      status_d = WDATA;
    end
  end

  always @* begin
    fsp_d = fsp_q;
    if (core_wr && fsp_sel) begin
      fsp_d = WDATA;
    end
  end

  always @* begin
    pc_latch_d = pc_latch_q;
    if (core_wr && latch_sel) begin
      pc_latch_d = WDATA;
    end
  end

  always @* begin
    int_ctrl_d = int_ctrl_q;
    if (core_wr && ictl_sel) begin
      int_ctrl_d = WDATA;
    end
  end

  // status resets to bank 0, so direct accesses start in bank 0
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      status_q <= `RST_STATUS;
    end else begin
      status_q <= status_d;
    end
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      fsp_q <= `RST_FSP;
    end else begin
      fsp_q <= fsp_d;
    end
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pc_latch_q <= `RST_PC_LATCH;
    end else begin
      pc_latch_q <= pc_latch_d;
    end
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      int_ctrl_q <= `RST_INT_CTRL;
    end else begin
      int_ctrl_q <= int_ctrl_d;
    end
  end

  // -----------------------------------------------------------------
  // storage writes
  // -----------------------------------------------------------------
  // no reset on the arrays, contents are undefined until written
  always @(posedge SYS_CLK) begin
    if (ram_we) begin
      ram[ridx] <= WDATA;
    end else if (sfr_we) begin
      special_function_space[sidx] <= WDATA;
    end
  end

  // -----------------------------------------------------------------
  // read path, data one cycle after the strobe
  // -----------------------------------------------------------------
  reg [7:0] core_rd;
  always @* begin
    core_rd = 8'h00;
    if (pcl_sel) begin
      core_rd = PC[7:0];
    end else if (st_sel) begin
      core_rd = status_q;
    end else if (fsp_sel) begin
      core_rd = fsp_q;
    end else if (latch_sel) begin
      core_rd = pc_latch_q;
    end else if (ictl_sel) begin
      core_rd = int_ctrl_q;
    end
  end

  reg [7:0] rd_d;
  always @* begin
    rd_d = 8'h00;
    if (self_ind) begin
      rd_d = 8'h00;
    end else if (kind == KIND_RAM) begin
      rd_d = ram[ridx];
    end else if (kind == KIND_SFR) begin
      rd_d = special_function_space[sidx];
    end else if (kind == KIND_CORE) begin
      rd_d = core_rd;
    end
  end

  // read data stand for one cycle only, zero otherwise
  reg [7:0] rdata_d;
  always @* begin
    rdata_d = 8'h00;
    if (RD) begin
      rdata_d = rd_d;
    end
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= rdata_d;
    end
  end

endmodule // memory_map_bank_decoder
`default_nettype wire

//--- dv/memory_map_bank_decoder_sva.sv
// port checker for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
module memory_map_bank_decoder_chk (
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        PC_LOAD,
  input wire logic [12:0] PC_LOAD_VAL,
  input wire logic        PC_INC,
  input wire logic        INT_ENTRY,
  input wire logic [6:0]  ADDR,
  input wire logic [7:0]  WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [7:0]  RDATA,
  input wire logic [12:0] PC,
  input wire logic [12:0] FETCH_ADDR,
  input wire logic [1:0]  BANK_SEL
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // writes that may reach the program counter or status, direct or through the pointer
  wire pc_wr = WR && (ADDR == 7'h02 || ADDR == 7'h00);
  wire st_wr = WR && (ADDR == 7'h03 || ADDR == 7'h00);
  sequence s_unimpl_rd;
    RD && BANK_SEL == 2'h3 && ADDR >= 7'h20 && ADDR < 7'h70;
  endsequence
  sequence s_zero_next;
    ##1 RDATA == 8'h00;
  endsequence
  chk_int_vector: assert property (INT_ENTRY |=> PC == 13'h0004)
    else $error("pc not at interrupt vector");
  chk_pc_load: assert property (PC_LOAD && !INT_ENTRY && !pc_wr |=>
    PC == $past(PC_LOAD_VAL)) else $error("pc load wrong");
  chk_pc_inc: assert property (PC_INC && !PC_LOAD && !INT_ENTRY && !pc_wr |=>
    PC == $past(PC) + 13'h0001) else $error("pc increment wrong");
  chk_fetch_wrap: assert property (FETCH_ADDR == (PC & 13'h0FFF))
    else $error("fetch address not wrapped");
  chk_bank_write: assert property (WR && ADDR == 7'h03 |=>
    BANK_SEL == $past(WDATA[6:5])) else $error("bank select not written");
  chk_bank_hold: assert property (!st_wr |=> $stable(BANK_SEL))
    else $error("bank select changed");
  chk_rd_idle: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data not zero");
  chk_unimpl_rd: assert property (s_unimpl_rd |-> s_zero_next)
    else $error("unimplemented byte not zero");
endmodule // memory_map_bank_decoder_chk
`default_nettype wire

//--- dv/cpu_core_model.sv
// core model driving fetch control and data strobes
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input  wire logic        SYS_CLK,
  input  wire logic [7:0]  RDATA,
  output var  logic        PC_LOAD,
  output var  logic [12:0] PC_LOAD_VAL,
  output var  logic        PC_INC,
  output var  logic        INT_ENTRY,
  output var  logic [6:0]  ADDR,
  output var  logic [7:0]  WDATA,
  output var  logic        WR,
  output var  logic        RD
);
  initial begin
    {PC_LOAD, PC_LOAD_VAL, PC_INC, INT_ENTRY, ADDR, WDATA, WR, RD} = '0;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge SYS_CLK);
    {ADDR, WDATA, WR} <= {a, v, 1'b1};
    @(posedge SYS_CLK);
    // released lines show the inverse, not the last value
    {ADDR, WDATA, WR} <= {~a, ~v, 1'b0};
    @(negedge SYS_CLK);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    @(posedge SYS_CLK);
    {ADDR, RD} <= {a, 1'b1};
    @(posedge SYS_CLK);
    {ADDR, RD} <= {~a, 1'b0};
    @(negedge SYS_CLK);
    v = RDATA;
  endtask
  task automatic pc_op(input logic ld, input logic [12:0] v, input logic inc, input logic irq);
    @(posedge SYS_CLK);
    {PC_LOAD, PC_LOAD_VAL, PC_INC, INT_ENTRY} <= {ld, v, inc, irq};
    @(posedge SYS_CLK);
    {PC_LOAD, PC_LOAD_VAL, PC_INC, INT_ENTRY} <= {1'b0, ~v, 2'h0};
    @(negedge SYS_CLK);
  endtask
endmodule // cpu_core_model
`default_nettype wire

//--- dv/memory_map_bank_decoder_tb.sv
// self-checking testbench for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
module memory_map_bank_decoder_tb;
  logic        SYS_CLK = 1'b0;
  logic        RST = 1'b1;
  wire         PC_LOAD, PC_INC, INT_ENTRY, WR, RD;
  wire  [12:0] PC_LOAD_VAL, PC, FETCH_ADDR;
  wire  [6:0]  ADDR;
  wire  [7:0]  WDATA, RDATA;
  wire  [1:0]  BANK_SEL;
  int          fail_count = 0;
  int          n_checks = 0;
  logic [7:0]  d;
  initial begin
    forever #25 SYS_CLK = ~SYS_CLK;
  end
  memory_map_bank_decoder #(.VARIANT(2'h2)) u_dut (.SYS_CLK(SYS_CLK), .RST(RST),
    .PC_LOAD(PC_LOAD), .PC_LOAD_VAL(PC_LOAD_VAL), .PC_INC(PC_INC), .INT_ENTRY(INT_ENTRY),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PC(PC),
    .FETCH_ADDR(FETCH_ADDR), .BANK_SEL(BANK_SEL));
  cpu_core_model u_cpu (.SYS_CLK(SYS_CLK), .RDATA(RDATA), .PC_LOAD(PC_LOAD),
    .PC_LOAD_VAL(PC_LOAD_VAL), .PC_INC(PC_INC), .INT_ENTRY(INT_ENTRY), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD));
  task automatic check(input string what, input logic [12:0] got, input logic [12:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(negedge SYS_CLK);
    check("pc", PC, 13'h0000);
    for (int b = 0; b < 4; b++) begin
      u_cpu.wr(7'h03, {1'b0, 2'(b), 5'h18});
      check("bank", 13'(BANK_SEL), 13'(b));
      u_cpu.wr(7'h0C, 8'h60 + 8'(b));
      u_cpu.wr(7'h21, 8'h30 + 8'(b));
      u_cpu.wr(7'h45, 8'h40 + 8'(b));
      u_cpu.wr(7'h70, 8'h50 + 8'(b));
    end
    u_cpu.wr(7'h04, 8'hA1);
    for (int b = 0; b < 4; b++) begin
      u_cpu.wr(7'h03, {1'b0, 2'(b), 5'h18});
      u_cpu.rd(7'h0C, d);
      check("sfr", 13'(d), 13'h60 + 13'(b));
      u_cpu.rd(7'h21, d);
      check("ram21", 13'(d), (b == 3) ? 13'h0 : 13'h30 + 13'(b));
      u_cpu.rd(7'h45, d);
      check("ram45", 13'(d), (b % 2) ? 13'h0 : 13'h40 + 13'(b));
      u_cpu.rd(7'h70, d);
      check("shared", 13'(d), 13'h0053);
      u_cpu.rd(7'h04, d);
      check("pointer", 13'(d), 13'h00A1);
    end
    u_cpu.wr(7'h03, 8'h18);
    u_cpu.rd(7'h00, d);
    check("indirect", 13'(d), 13'h0031);
    u_cpu.wr(7'h00, 8'h99);
    u_cpu.wr(7'h03, 8'h38);
    u_cpu.rd(7'h21, d);
    check("ind wr", 13'(d), 13'h0099);
    u_cpu.pc_op(1'b0, 13'h0000, 1'b1, 1'b0);
    check("pc inc", PC, 13'h0001);
    u_cpu.pc_op(1'b1, 13'h1FFF, 1'b1, 1'b0);
    check("pc load", PC, 13'h1FFF);
    check("fetch", FETCH_ADDR, 13'h0FFF);
    u_cpu.pc_op(1'b0, 13'h0000, 1'b1, 1'b0);
    check("pc wrap", PC, 13'h0000);
    u_cpu.pc_op(1'b1, 13'h0123, 1'b1, 1'b1);
    check("int", PC, 13'h0004);
    u_cpu.wr(7'h0A, 8'h05);
    u_cpu.wr(7'h02, 8'h34);
    check("pc write", PC, 13'h0534);
    final_report();
  end
  initial begin
    repeat (5000) @(posedge SYS_CLK);
    fail_count++;
    final_report();
  end
endmodule // memory_map_bank_decoder_tb
bind memory_map_bank_decoder memory_map_bank_decoder_chk u_chk (.SYS_CLK(SYS_CLK),
  .RST(RST), .PC_LOAD(PC_LOAD), .PC_LOAD_VAL(PC_LOAD_VAL), .PC_INC(PC_INC),
  .INT_ENTRY(INT_ENTRY), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .PC(PC), .FETCH_ADDR(FETCH_ADDR), .BANK_SEL(BANK_SEL));
`default_nettype wire
